// ---- logic/hcr_bank.sv ----
`timescale 1ns/1ns
module hcr_bank
  import hcr_pkg::*;
#(
  parameter logic [6:0]       SLAVE_ADDR = 7'h2c,  // arbitrary value
  parameter logic [OC_CW-1:0] OC_CYC0    = OC_CYCLES0,
  parameter logic [OC_CW-1:0] OC_CYC1    = OC_CYCLES1,
  parameter logic [OC_CW-1:0] OC_CYC2    = OC_CYCLES2,
  parameter logic [OC_CW-1:0] OC_CYC3    = OC_CYCLES3
) (
  // system
  input  wire logic   clk,
  input  wire logic   rst,
  // serial management pins
  input  wire logic   scl_in,
  input  wire logic   sda_in,
  output logic        sda_out,
  output logic        sda_oe_n,
  // power detect and lock
  input  wire logic   local_power_detect_pin,
  input  wire logic   config_lock,
  // settings to the hub core
  output hcr_hub_cfg_t hub_cfg
);

  //==========================================================
  // pin synchronisers
  logic [2:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       pwr_s;

  hcr_sync #(
    .W (3)
  ) u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  ({local_power_detect_pin, sda_in, scl_in}),
    .dout (pins_s)
  );

  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign pwr_s = pins_s[2];

  //==========================================================
  // state
  hcr_state_t s_reg;
  hcr_state_t s_next;

  // bus events from synchronised pins
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  assign scl_rise   = scl_s & ~s_reg.scl_d;
  assign scl_fall   = ~scl_s & s_reg.scl_d;
  assign start_cond = scl_s & s_reg.scl_d & s_reg.sda_d & ~sda_s;
  assign stop_cond  = scl_s & s_reg.scl_d & ~s_reg.sda_d & sda_s;

  //==========================================================
  // register read mux, unmapped offsets read zero
  function automatic logic [7:0] read_reg(input hcr_state_t s, input logic [7:0] ofs);
    logic [7:0] v;
    v = 8'h00;
    case (ofs)
      OFS_DEVICE_CODE_HIGH: v = s.code_hi;
      OFS_CONFIG_ONE:       v = s.cfg1;
      OFS_CONFIG_TWO:       v = s.hub_config_byte_two & MASK_CONFIG_TWO;
      OFS_FIXED_PORT_MAP:   v = s.fixed_map & MASK_PORT_MAP;
      OFS_PORT_OFF_MAP:     v = s.off_map & MASK_PORT_MAP;
      default:              v = 8'h00;
    endcase
    return v;
  endfunction

  // selected filter delay in cycles
  function automatic logic [OC_CW-1:0] oc_cycles(input logic [1:0] sel);
    logic [OC_CW-1:0] c;
    c = OC_CYC0;
    case (sel)
      2'h0:    c = OC_CYC0;
      2'h1:    c = OC_CYC1;
      2'h2:    c = OC_CYC2;
      2'h3:    c = OC_CYC3;
      default: c = OC_CYC0;
    endcase
    return c;
  endfunction

  //==========================================================
  // next state
  logic [7:0] rd_byte;
  logic       self_mode;

  always_comb begin
    s_next       = s_reg;
    s_next.scl_d = scl_s;
    s_next.sda_d = sda_s;
    rd_byte      = read_reg(s_reg, s_reg.ptr);

    if (start_cond) begin
      // start or repeated start, pointer kept for reads
      s_next.st      = SMB_ADDR;
      s_next.bit_cnt = 4'h0;
      s_next.drive   = 1'b0;
    end else if (stop_cond) begin
      s_next.st    = SMB_IDLE;
      s_next.drive = 1'b0;
    end else begin
      // sample on rising clock
      if (scl_rise) begin
        case (s_reg.st)
          SMB_ADDR, SMB_CMD, SMB_WDATA: begin
            if (s_reg.bit_cnt < BITS_PER_BYTE) begin
              s_next.shift   = {s_reg.shift[6:0], sda_s};
              s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
            end
          end
          SMB_RDATA: begin
            if (s_reg.bit_cnt < BITS_PER_BYTE) begin
              s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
            end
          end
          SMB_RACK: begin
            s_next.nack = sda_s;
          end
          default: begin
          end
        endcase
      end

      // drive and advance on falling clock
      if (scl_fall) begin
        case (s_reg.st)
          SMB_ADDR: begin
            if (s_reg.bit_cnt == BITS_PER_BYTE) begin
              if (s_reg.shift[7:1] == SLAVE_ADDR) begin
                s_next.rw    = s_reg.shift[0];
                s_next.drive = 1'b1;
                s_next.st    = SMB_ACK_ADDR;
              end else begin
                s_next.st = SMB_IDLE;
              end
            end
          end
          SMB_CMD: begin
            if (s_reg.bit_cnt == BITS_PER_BYTE) begin
              s_next.ptr   = s_reg.shift;
              s_next.drive = 1'b1;
              s_next.st    = SMB_ACK_CMD;
            end
          end
          SMB_WDATA: begin
            if (s_reg.bit_cnt == BITS_PER_BYTE) begin
              // locked writes are acknowledged and dropped
              if (!config_lock) begin
                case (s_reg.ptr)
                  OFS_DEVICE_CODE_HIGH: s_next.code_hi = s_reg.shift;
                  OFS_CONFIG_ONE:       s_next.cfg1    = s_reg.shift;
                  OFS_CONFIG_TWO:       s_next.hub_config_byte_two    = s_reg.shift & MASK_CONFIG_TWO;
                  OFS_FIXED_PORT_MAP:   s_next.fixed_map = s_reg.shift & MASK_PORT_MAP;
                  OFS_PORT_OFF_MAP:     s_next.off_map = s_reg.shift & MASK_PORT_MAP;
                  default: begin
                  end
                endcase
              end
              s_next.ptr   = s_reg.ptr + 8'h01;
              s_next.drive = 1'b1;
              s_next.st    = SMB_ACK_WDATA;
            end
          end
          SMB_ACK_ADDR: begin
            s_next.bit_cnt = 4'h0;
            if (s_reg.rw) begin
              s_next.shift = rd_byte;
              s_next.drive = ~rd_byte[7];
              s_next.st    = SMB_RDATA;
            end else begin
              s_next.drive = 1'b0;
              s_next.st    = SMB_CMD;
            end
          end
          SMB_ACK_CMD, SMB_ACK_WDATA: begin
            s_next.bit_cnt = 4'h0;
            s_next.drive   = 1'b0;
            s_next.st      = SMB_WDATA;
          end
          SMB_RDATA: begin
            if (s_reg.bit_cnt == BITS_PER_BYTE) begin
              s_next.drive = 1'b0;
              s_next.ptr   = s_reg.ptr + 8'h01;
              s_next.st    = SMB_RACK;
            end else begin
              s_next.shift = {s_reg.shift[6:0], 1'b0};
              s_next.drive = ~s_reg.shift[6];
            end
          end
          SMB_RACK: begin
            if (s_reg.nack) begin
              s_next.st = SMB_IDLE;
            end else begin
              s_next.bit_cnt = 4'h0;
              s_next.shift   = rd_byte;
              s_next.drive   = ~rd_byte[7];
              s_next.st      = SMB_RDATA;
            end
          end
          SMB_IDLE: begin
            s_next.drive = 1'b0;
          end
          default: begin
            s_next.st    = SMB_IDLE;
            s_next.drive = 1'b0;
          end
        endcase
      end
    end

    // decoded settings, registered toward the hub core
    self_mode = s_reg.hub_config_byte_two[C2_DYNAMIC] ? pwr_s : s_reg.cfg1[C1_POWER_SOURCE];
    s_next.cfg.device_code_high_byte      = s_reg.code_hi;
    s_next.cfg.self_powered               = self_mode;
    s_next.cfg.led_indicator_present      = s_reg.cfg1[C1_LED];
    s_next.cfg.full_speed_only            = s_reg.cfg1[C1_FULL_SPEED];
    s_next.cfg.per_port_translator        = s_reg.cfg1[C1_TRANSLATOR];
    s_next.cfg.suppress_frame_end_marker  = s_reg.cfg1[C1_SUPPRESS_EOP];
    s_next.cfg.overcurrent_sensing_scheme = s_reg.cfg1[C1_SENSE_HI:C1_SENSE_LO];
    s_next.cfg.sensing_config_error       = s_reg.cfg1[C1_SENSE_HI] & self_mode;
    s_next.cfg.power_switch_granularity   = s_reg.cfg1[C1_SWITCHING];
    s_next.cfg.dynamic_fallback           = s_reg.hub_config_byte_two[C2_DYNAMIC];
    s_next.cfg.overcurrent_filter_delay   = s_reg.hub_config_byte_two[C2_TIMER_HI:C2_TIMER_LO];
    s_next.cfg.overcurrent_filter_cycles  =
      oc_cycles(s_reg.hub_config_byte_two[C2_TIMER_HI:C2_TIMER_LO]);
    s_next.cfg.compound_device            = s_reg.hub_config_byte_two[C2_COMPOUND];
    s_next.cfg.fixed_attachment_ports     = s_reg.fixed_map[PORT_HI:PORT_LO];
    s_next.cfg.disabled_ports_local_power =
      self_mode ? s_reg.off_map[PORT_HI:PORT_LO] : '0;
  end

  //==========================================================
  // state registers, everything clears on reset except the sampled clock and data levels, which load one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg           <= '0;
      s_reg.st        <= SMB_IDLE;
      s_reg.scl_d     <= 1'b1;
      s_reg.sda_d     <= 1'b1;
      s_reg.code_hi   <= REG_RESET;
      s_reg.cfg1      <= REG_RESET;
      s_reg.hub_config_byte_two      <= REG_RESET;
      s_reg.fixed_map <= REG_RESET;
      s_reg.off_map   <= REG_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  //==========================================================
  // outputs, open drain pulls low only
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~s_reg.drive;
  assign hub_cfg  = s_reg.cfg;

endmodule

// ---- include/hcr_pkg.sv ----
//==========================================================
// Contract
// - device code high byte register holds bits 7:0 of identifier upper half
// - first config byte bit 7: zero bus powered, one self powered
// - with dynamic switching on, power mode follows local power detect pin
// - first config byte bit 6 reports whether led port indicators exist
// - first config byte bit 5 one forces full speed only attachment
// - first config byte bit 4: shared translator or one per port
// - first config byte bit 3 one suppresses end marker at frame point
// - bits 2:1 pick ganged, per port or no sensing; none only bus powered
// - first config byte bit 0: ganged or per port power switching
// - second config byte bit 7 enables automatic fallback to bus power
// - second config byte bits 5:4 pick filter delay 0.1, 2, 4, 6 ms
// - second config byte bit 3 marks hub as part of compound device
// - fixed port map bits 3:1 mark ports 3:1 non removable
// - bit zero of each port bitmap is reserved and reads zero
// - in self powered mode, off map bits 3:1 disable ports 3:1
// - all five registers reset to 0x00
// - once lock is set, writes to the configuration range are rejected; here they are acknowledged and dropped only while config_lock is high
package hcr_pkg;

  //==========================================================
  // register offsets and reset value
  localparam logic [7:0] OFS_DEVICE_CODE_HIGH = 8'h06;
  localparam logic [7:0] OFS_CONFIG_ONE       = 8'h07;
  localparam logic [7:0] OFS_CONFIG_TWO       = 8'h08;
  localparam logic [7:0] OFS_FIXED_PORT_MAP   = 8'h09;
  localparam logic [7:0] OFS_PORT_OFF_MAP     = 8'h0a;
  localparam logic [7:0] REG_RESET            = 8'h00;

  //==========================================================
  // writable bit masks, reserved positions are zero
  localparam logic [7:0] MASK_CONFIG_TWO = 8'hb8;
  localparam logic [7:0] MASK_PORT_MAP   = 8'h0e;

  //==========================================================
  // field positions
  localparam int unsigned C1_POWER_SOURCE = 7;
  localparam int unsigned C1_LED          = 6;
  localparam int unsigned C1_FULL_SPEED   = 5;
  localparam int unsigned C1_TRANSLATOR   = 4;
  localparam int unsigned C1_SUPPRESS_EOP = 3;
  localparam int unsigned C1_SENSE_HI     = 2;
  localparam int unsigned C1_SENSE_LO     = 1;
  localparam int unsigned C1_SWITCHING    = 0;
  localparam int unsigned C2_DYNAMIC      = 7;
  localparam int unsigned C2_TIMER_HI     = 5;
  localparam int unsigned C2_TIMER_LO     = 4;
  localparam int unsigned C2_COMPOUND     = 3;
  localparam int unsigned PORT_LO         = 1;
  localparam int unsigned PORT_HI         = 3;
  localparam int unsigned NUM_PORTS       = 3;

  //==========================================================
  // filter delays in microseconds and cycles at the core clock
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned OC_DELAY0_US = 100;
  localparam int unsigned OC_DELAY1_US = 2000;
  localparam int unsigned OC_DELAY2_US = 4000;
  localparam int unsigned OC_DELAY3_US = 6000;
  localparam int unsigned OC_CW        = 20;
  localparam logic [OC_CW-1:0] OC_CYCLES0 = OC_CW'(OC_DELAY0_US * CLK_MHZ);
  localparam logic [OC_CW-1:0] OC_CYCLES1 = OC_CW'(OC_DELAY1_US * CLK_MHZ);
  localparam logic [OC_CW-1:0] OC_CYCLES2 = OC_CW'(OC_DELAY2_US * CLK_MHZ);
  localparam logic [OC_CW-1:0] OC_CYCLES3 = OC_CW'(OC_DELAY3_US * CLK_MHZ);

  //==========================================================
  // serial slave states and constants
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [3:0] {
    SMB_IDLE      = 4'h0,
    SMB_ADDR      = 4'h1,
    SMB_ACK_ADDR  = 4'h2,
    SMB_CMD       = 4'h3,
    SMB_ACK_CMD   = 4'h4,
    SMB_WDATA     = 4'h5,
    SMB_ACK_WDATA = 4'h6,
    SMB_RDATA     = 4'h7,
    SMB_RACK      = 4'h8
  } hcr_smb_state_t;

  //==========================================================
  // settings handed to the hub core
  typedef struct packed {
    logic [7:0]           device_code_high_byte;
    logic                 self_powered;
    logic                 led_indicator_present;
    logic                 full_speed_only;
    logic                 per_port_translator;
    logic                 suppress_frame_end_marker;
    logic [1:0]           overcurrent_sensing_scheme;
    logic                 sensing_config_error;
    logic                 power_switch_granularity;
    logic                 dynamic_fallback;
    logic [1:0]           overcurrent_filter_delay;
    logic [OC_CW-1:0]     overcurrent_filter_cycles;
    logic                 compound_device;
    logic [NUM_PORTS-1:0] fixed_attachment_ports;
    logic [NUM_PORTS-1:0] disabled_ports_local_power;
  } hcr_hub_cfg_t;

  //==========================================================
  // full state of the bank
  typedef struct packed {
    hcr_smb_state_t st;
    logic [3:0]     bit_cnt;
    logic [7:0]     shift;
    logic [7:0]     ptr;
    logic           rw;
    logic           nack;
    logic           drive;
    logic           scl_d;
    logic           sda_d;
    logic [7:0]     code_hi;
    logic [7:0]     cfg1;
    logic [7:0]     hub_config_byte_two;
    logic [7:0]     fixed_map;
    logic [7:0]     off_map;
    hcr_hub_cfg_t   cfg;
  } hcr_state_t;

endpackage

// ---- logic/hcr_sync.sv ----
`timescale 1ns/1ns
module hcr_sync #(
  parameter int unsigned W = 3
) (
  // system
  input  wire logic         clk,
  input  wire logic         rst,
  // pins and synchronised copies
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } hcr_sync_state_t;

  hcr_sync_state_t s_reg;
  hcr_sync_state_t s_next;

  // first stage feeds only the second stage
  always_comb begin
    s_next    = s_reg;
    s_next.s1 = din;
    s_next.s2 = s_reg.s1;
  end

  // state registers, reset to the idle high level of the bus pins so no false edge follows
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign dout = s_reg.s2;

endmodule

// ---- bench/hcr_host.sv ----
`timescale 1ns/1ns
//==========================================================
// serial host loading the settings over the management pins
module hcr_host (
  // system
  input  wire logic clk,
  // bus lines
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  // both lines released, clock stands high between frames
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  // one bus phase of ten core clocks
  task automatic tick();
    repeat (10) @(posedge clk);
  endtask
  // start, also a repeated start from clock low
  task automatic start();
    sda_low <= 1'b0;
    tick();
    scl <= 1'b1;
    tick();
    sda_low <= 1'b1;
    tick();
    scl <= 1'b0;
    tick();
  endtask
  // stop: data rises while the clock is high
  task automatic stop();
    sda_low <= 1'b1;
    tick();
    scl <= 1'b1;
    tick();
    sda_low <= 1'b0;
    tick();
  endtask
  // nine bits; data moves only in the low phase, sampled late in the high phase
  task automatic xbyte(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      sda_low <= ~d[i];
      tick();
      scl <= 1'b1;
      tick();
      r[i] = sda_line;
      scl <= 1'b0;
      tick();
    end
  endtask
  // register write, ok when all three bytes were acknowledged
  task automatic wr(input logic [6:0] a, input logic [7:0] o, input logic [7:0] v,
                    output logic ok);
    logic [8:0] r0, r1, r2;
    start();
    xbyte({a, 1'b0, 1'b1}, r0);
    xbyte({o, 1'b1}, r1);
    xbyte({v, 1'b1}, r2);
    stop();
    ok = ~(r0[0] | r1[0] | r2[0]);
  endtask
  // register read, single byte ended by a not-acknowledge
  task automatic rd(input logic [6:0] a, input logic [7:0] o, output logic [7:0] v);
    logic [8:0] r;
    start();
    xbyte({a, 1'b0, 1'b1}, r);
    xbyte({o, 1'b1}, r);
    start();
    xbyte({a, 1'b1, 1'b1}, r);
    xbyte(9'h1ff, r);
    v = r[8:1];
    stop();
  endtask
endmodule

// ---- bench/hcr_bank_asserts.sv ----
`timescale 1ns/1ns
//==========================================================
// settings checker
module hcr_bank_asserts
  import hcr_pkg::*;
#(
  parameter logic [OC_CW-1:0] OC_CYC0 = OC_CYCLES0,
  parameter logic [OC_CW-1:0] OC_CYC1 = OC_CYCLES1,
  parameter logic [OC_CW-1:0] OC_CYC2 = OC_CYCLES2,
  parameter logic [OC_CW-1:0] OC_CYC3 = OC_CYCLES3
) (
  // system
  input wire logic         clk,
  input wire logic         rst,
  // pins
  input wire logic         scl_in,
  input wire logic         sda_in,
  input wire logic         sda_out,
  input wire logic         sda_oe_n,
  input wire logic         local_power_detect_pin,
  input wire logic         config_lock,
  // settings
  input wire hcr_hub_cfg_t hub_cfg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [OC_CW-1:0] exp_cyc;
  // expected filter length from the delay code
  always_comb begin
    case (hub_cfg.overcurrent_filter_delay)
      2'b00:   exp_cyc = OC_CYC0;
      2'b01:   exp_cyc = OC_CYC1;
      2'b10:   exp_cyc = OC_CYC2;
      default: exp_cyc = OC_CYC3;
    endcase
  end
  reset_clear_a: assert property ($fell(rst) |-> hub_cfg == '0)
    else $error("settings not clear after reset");
  filter_map_a: assert property (!$past(rst) |-> hub_cfg.overcurrent_filter_cycles == exp_cyc)
    else $error("filter length does not match delay code");
  sense_flag_a: assert property (hub_cfg.sensing_config_error ==
    (hub_cfg.overcurrent_sensing_scheme[1] & hub_cfg.self_powered))
    else $error("sensing error flag wrong");
  port_off_a: assert property (!hub_cfg.self_powered |->
    hub_cfg.disabled_ports_local_power == 3'h0)
    else $error("ports disabled while bus powered");
  fallback_up_a: assert property (hub_cfg.dynamic_fallback && $rose(local_power_detect_pin)
    |-> ##[1:6] hub_cfg.self_powered)
    else $error("no return to local power");
  fallback_down_a: assert property (hub_cfg.dynamic_fallback && $fell(local_power_detect_pin)
    |-> ##[1:6] !hub_cfg.self_powered)
    else $error("no fallback to bus power");
  pin_ignored_a: assert property (!hub_cfg.dynamic_fallback && $changed(local_power_detect_pin)
    |=> $stable(hub_cfg.self_powered) [*6])
    else $error("power mode followed pin without dynamic switching");
  sda_low_only_a: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  lock_hold_a: assert property (config_lock && $past(config_lock, 3)
    |-> $stable(hub_cfg.device_code_high_byte) && $stable(hub_cfg.compound_device))
    else $error("settings changed while locked");
endmodule
bind hcr_bank hcr_bank_asserts #(
  .OC_CYC0(OC_CYC0),
  .OC_CYC1(OC_CYC1),
  .OC_CYC2(OC_CYC2),
  .OC_CYC3(OC_CYC3)
) u_asserts (
  .clk(clk),
  .rst(rst),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .sda_out(sda_out),
  .sda_oe_n(sda_oe_n),
  .local_power_detect_pin(local_power_detect_pin),
  .config_lock(config_lock),
  .hub_cfg(hub_cfg)
);

// ---- bench/tb_hcr_bank.sv ----
`timescale 1ns/1ns
//==========================================================
// bank testbench
module tb_hcr_bank;
  import hcr_pkg::*;
  localparam logic [6:0] ADDR = 7'h2c;  // arbitrary value
  logic               clk, rst, pwr, lock, sda_oe_n, sda_out, scl, sda_low, ok;
  logic         [7:0] rv;
  hcr_hub_cfg_t       hub_cfg;
  int                 err_count, checked;
  logic        [19:0] cyc[4] = '{20'h0000a, 20'h00014, 20'h00028, 20'h0003c};
  logic         [7:0] wv[5] = '{8'ha5, 8'hff, 8'hff, 8'hff, 8'hff};
  logic         [7:0] ev[5] = '{8'ha5, 8'hff, 8'hb8, 8'h0e, 8'h0e};
  // open-drain data line with pull-up
  wire logic          sda_line = ~(sda_low | ~sda_oe_n);
  hcr_bank #(.SLAVE_ADDR(ADDR), .OC_CYC0(20'h0000a), .OC_CYC1(20'h00014),
             .OC_CYC2(20'h00028), .OC_CYC3(20'h0003c)) DUT (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .local_power_detect_pin(pwr), .config_lock(lock),
    .hub_cfg(hub_cfg));
  hcr_host u_host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // counts and verdict
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // register access, writes with acknowledge check, reads with value check only
  task automatic wr(input logic [7:0] o, input logic [7:0] v);
    u_host.wr(ADDR, o, v, ok);
    check(ok, 1'b1);
  endtask
  task automatic rdchk(input logic [7:0] o, input logic [7:0] e);
    u_host.rd(ADDR, o, rv);
    check(rv, e);
  endtask
  task automatic settle();
    repeat (10) @(posedge clk);
  endtask
  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // watchdog
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    end_of_test();
  end
  // main sequence
  initial begin
    rst  = 1'b1;
    pwr  = 1'b1;
    lock = 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    settle();
    check(hub_cfg.overcurrent_filter_cycles, cyc[0]);
    for (int i = 0; i < 5; i++) rdchk(OFS_DEVICE_CODE_HIGH + 8'(i), 8'h00);
    $display("reset values done");
    for (int i = 0; i < 5; i++) wr(OFS_DEVICE_CODE_HIGH + 8'(i), wv[i]);
    for (int i = 0; i < 5; i++) rdchk(OFS_DEVICE_CODE_HIGH + 8'(i), ev[i]);
    check(hub_cfg.device_code_high_byte, 8'ha5);
    check({hub_cfg.self_powered, hub_cfg.led_indicator_present, hub_cfg.full_speed_only,
           hub_cfg.per_port_translator, hub_cfg.suppress_frame_end_marker,
           hub_cfg.overcurrent_sensing_scheme, hub_cfg.sensing_config_error,
           hub_cfg.power_switch_granularity}, 9'h1ff);
    check({hub_cfg.dynamic_fallback, hub_cfg.overcurrent_filter_delay,
           hub_cfg.overcurrent_filter_cycles}, {3'h7, cyc[3]});
    check({hub_cfg.compound_device, hub_cfg.fixed_attachment_ports,
           hub_cfg.disabled_ports_local_power}, 7'h7f);
    $display("register map done");
    for (int k = 0; k < 4; k++) begin
      wr(OFS_CONFIG_TWO, {2'h0, 2'(k), 4'h0});
      check({hub_cfg.self_powered, hub_cfg.overcurrent_filter_delay,
             hub_cfg.overcurrent_filter_cycles}, {1'b1, 2'(k), cyc[k]});
    end
    wr(OFS_CONFIG_ONE, 8'h7f);
    check({hub_cfg.self_powered, hub_cfg.sensing_config_error,
           hub_cfg.disabled_ports_local_power}, 5'h00);
    $display("filter codes done");
    wr(OFS_CONFIG_TWO, 8'h80);
    check(hub_cfg.self_powered, 1'b1);
    pwr <= 1'b0;
    settle();
    check(hub_cfg.self_powered, 1'b0);
    pwr <= 1'b1;
    settle();
    check(hub_cfg.self_powered, 1'b1);
    wr(OFS_CONFIG_TWO, 8'h00);
    check(hub_cfg.self_powered, 1'b0);
    pwr <= 1'b0;
    settle();
    pwr <= 1'b1;
    settle();
    check(hub_cfg.self_powered, 1'b0);
    $display("dynamic power done");
    lock <= 1'b1;
    wr(OFS_DEVICE_CODE_HIGH, 8'h3c);
    rdchk(OFS_DEVICE_CODE_HIGH, 8'ha5);
    lock <= 1'b0;
    wr(OFS_DEVICE_CODE_HIGH, 8'h3c);
    rdchk(OFS_DEVICE_CODE_HIGH, 8'h3c);
    $display("lock done");
    end_of_test();
  end
endmodule
